// >>> include/fdc_map.vh
// constants for the four-decade counter and display scanner
`ifndef FDC_MAP_VH
`define FDC_MAP_VH
// register byte offsets
`define FDC_OFF_CTRL 4'h0
`define FDC_OFF_STAT 4'h4
`define FDC_OFF_LATCH 4'h8
`define FDC_OFF_COUNT 4'hc
// control register fields
`define FDC_CTRL_RESET_N 0
`define FDC_CTRL_XFER_N 1
`define FDC_CTRL_BLANK_N 2
`define FDC_CTRL_TRUE 3
`define FDC_CTRL_DP_LEFT 4
`define FDC_CTRL_RST 32'h0000_001f
// digit select codes, one-hot, msd first
`define FDC_SEL_MSD 4'h8
`define FDC_SEL_LSD 4'h1
// decade limits
`define FDC_DEC_NINE 4'h9
`define FDC_DEC_ZERO 4'h0
// axi responses
`define FDC_RESP_OKAY 2'h0
`define FDC_RESP_SLVERR 2'h2
// timing: transfer release and reset spacing in ns, and clock period
`define FDC_T_XFER_NS 1000
`define FDC_CLK_NS 40
`endif

// >>> rtl/fdc_latch.v
// static display latches holding four decades
`timescale 1ns/1ps
module fdc_latch (
    // clock
    input wire aclk,
    // capture control
    input wire load,
    input wire [15:0] din,
    // latched count, registered
    output reg [15:0] dout
);
    // ------------------------------------------------------------
    // latch storage
    // ------------------------------------------------------------
    // copy count while load is high; no reset, as in the device
    // contents stay unknown until the first transfer has run
    always @(posedge aclk) begin
        if (load) begin
            dout <= din;
        end
    end
endmodule

// >>> rtl/fdc_top.v
// four-decade counter with latches, display scanner and axi4-lite registers
//
// Overview of operation
// R01 - count falling edge advances modulo 10000 counter
// R02 - scan falling edge advances digit selector
// R03 - one-hot select msd to lsd, routes latch
// R04 - scan low forces outputs to off level
// R05 - transfer low copies counter into latches
// R06 - transfer ends at next count edge
// R07 - partner spaces reset after transfer by 1us
// R08 - reset clears counter, selects msd, clears overflow
// R09 - partner keeps scan much faster than reset
// R10 - blank leading zeros until nonzero or point
// R11 - blanking segments only, lsd shown, re-arms
// R12 - reset while unblanked gives unblanked scan
// R13 - partner holds blanking low during reset
// R14 - partner pulls point low on its digit
// R15 - blanking input low: segments off, bcd zero
// R16 - complement mode inverts bcd and segments
// R17 - right point mode unblanks one digit later
// R18 - overflow flag low on 10000th count
// R19 - carry out high while counter holds 9999
// R20 - fixed seven-segment and bcd decode table
// R21 - counter wraps to zero and keeps counting
`timescale 1ns/1ps
`include "fdc_map.vh"
module fdc_top (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // device inputs, synchronous to aclk
    input wire count_in,
    input wire scan_in,
    input wire dp_n,
    // display outputs
    output reg [6:0] seg_out,
    output reg [3:0] bcd_out,
    output reg [3:0] digit_sel,
    output reg overflow_n,
    output reg carry_out
);
    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    // transfer spacing in cycles, round up, at least one
    localparam integer XFER_CYC_RAW = (`FDC_T_XFER_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS;
    localparam integer XFER_CYC = (XFER_CYC_RAW < 1) ? 1 : XFER_CYC_RAW;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // seven-segment pattern {g..a}, 0 = lit, true polarity
    function [6:0] seg_dec;
        input [3:0] d;
        begin
            case (d)
                4'h0: seg_dec = 7'h40;
                4'h1: seg_dec = 7'h79;
                4'h2: seg_dec = 7'h24;
                4'h3: seg_dec = 7'h30;
                4'h4: seg_dec = 7'h19;
                4'h5: seg_dec = 7'h12;
                4'h6: seg_dec = 7'h02;
                4'h7: seg_dec = 7'h78;
                4'h8: seg_dec = 7'h00;
                4'h9: seg_dec = 7'h10;
                default: seg_dec = 7'h7f;
            endcase
        end
    endfunction

    // one decade increment with carry
    function [4:0] dec_inc;
        input [3:0] d;
        input cin;
        begin
            if (!cin) begin
                dec_inc = {1'b0, d};
            end else if (d == `FDC_DEC_NINE) begin
                dec_inc = {1'b1, `FDC_DEC_ZERO};
            end else begin
                dec_inc = {1'b0, d + 4'h1};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    reg [31:0] ctrl_reg; // software control bits
    wire sw_reset_n = ctrl_reg[`FDC_CTRL_RESET_N]; // counter reset, low active
    wire xfer_n = ctrl_reg[`FDC_CTRL_XFER_N]; // transfer, low active
    wire blank_n = ctrl_reg[`FDC_CTRL_BLANK_N]; // blanking input, low active
    wire true_pol = ctrl_reg[`FDC_CTRL_TRUE]; // 1 = true data
    wire dp_left = ctrl_reg[`FDC_CTRL_DP_LEFT]; // 1 = point left
    wire clr_n = aresetn & sw_reset_n; // combined device reset

    // ------------------------------------------------------------
    // edge detection on synchronous inputs
    // ------------------------------------------------------------
    reg count_d_reg; // previous count level
    reg scan_d_reg; // previous scan level
    reg dp_d_reg; // previous point level
    wire count_fall = count_d_reg & ~count_in;
    wire scan_fall = scan_d_reg & ~scan_in;
    wire dp_fall = dp_d_reg & ~dp_n;

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_d_reg <= 1'b0;
            scan_d_reg <= 1'b0;
            dp_d_reg <= 1'b1;
        end else begin
            count_d_reg <= count_in;
            scan_d_reg <= scan_in;
            dp_d_reg <= dp_n;
        end
    end

    // ------------------------------------------------------------
    // decade counter
    // ------------------------------------------------------------
    reg [15:0] cnt_reg; // four bcd decades, msd in top nibble
    reg [15:0] cnt_next;
    reg [4:0] s0;
    reg [4:0] s1;
    reg [4:0] s2;
    reg [4:0] s3;

    // synchronous ripple-free increment of all decades
    always @* begin
        s0 = dec_inc(cnt_reg[3:0], 1'b1);
        s1 = dec_inc(cnt_reg[7:4], s0[4]);
        s2 = dec_inc(cnt_reg[11:8], s1[4]);
        s3 = dec_inc(cnt_reg[15:12], s2[4]);
        cnt_next = {s3[3:0], s2[3:0], s1[3:0], s0[3:0]};
    end

    // counter, overflow flag and carry out
    always @(posedge aclk) begin
        if (!clr_n) begin
            cnt_reg <= 16'h0000; // see R08
            overflow_n <= 1'b1; // see R08
            carry_out <= 1'b0;
        end else if (count_fall) begin
            cnt_reg <= cnt_next; // see R01 see R21
            if (s3[4]) begin
                overflow_n <= 1'b0; // see R18
            end
            carry_out <= (cnt_next == 16'h9999); // see R19
        end
    end

    // ------------------------------------------------------------
    // transfer control and latches
    // ------------------------------------------------------------
    reg xfer_act_reg; // transfer still in progress
    reg [15:0] xfer_cnt_reg; // cycles since transfer release, for spacing
    wire [15:0] latch_q;

    // transfer runs while input low and until next count edge after release
    always @(posedge aclk) begin
        if (!aresetn) begin
            xfer_act_reg <= 1'b0;
        end else if (!xfer_n) begin
            xfer_act_reg <= 1'b1; // see R05
        end else if (count_fall) begin
            xfer_act_reg <= 1'b0; // see R06
        end
    end

    // release age counter, compared to the spacing in a readable flag so software can respect spacing
    always @(posedge aclk) begin
        if (!aresetn || !xfer_n) begin
            xfer_cnt_reg <= 16'h0000;
        end else if (xfer_cnt_reg != 16'hffff) begin
            xfer_cnt_reg <= xfer_cnt_reg + 16'h0001; // see R07
        end
    end
    wire xfer_spaced = (xfer_cnt_reg >= XFER_CYC[15:0]);

    // capture closes on the count edge itself, before the new value lands
    fdc_latch u_latch (
        .aclk(aclk),
        .load(xfer_act_reg | ~xfer_n), // see R05 see R06
        .din(cnt_reg),
        .dout(latch_q)
    );

    // ------------------------------------------------------------
    // digit selector
    // ------------------------------------------------------------
    reg [3:0] sel_reg; // one-hot, msd at bit 3

    always @(posedge aclk) begin
        if (!clr_n) begin
            sel_reg <= `FDC_SEL_MSD; // see R08
        end else if (scan_fall) begin
            sel_reg <= {sel_reg[0], sel_reg[3:1]}; // see R02 see R03
        end
    end

    // selected latched decade
    reg [3:0] digit;
    always @* begin
        case (sel_reg)
            4'h8: digit = latch_q[15:12];
            4'h4: digit = latch_q[11:8];
            4'h2: digit = latch_q[7:4];
            4'h1: digit = latch_q[3:0];
            default: digit = `FDC_DEC_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // leading zero blanking
    // ------------------------------------------------------------
    reg unblank_reg; // 1 = unblanked mode this scan
    reg dp_pend_reg; // right mode: point seen, unblank at next digit
    wire is_lsd = (sel_reg == `FDC_SEL_LSD);
    wire zero_dig = (digit == `FDC_DEC_ZERO);
    wire blank_now = ~unblank_reg & zero_dig & ~is_lsd; // see R10 see R11

    // unblank state survives the control-register reset, so a reset while unblanked leaves it set
    always @(posedge aclk) begin
        if (!aresetn) begin
            unblank_reg <= 1'b0;
            dp_pend_reg <= 1'b0;
        end else if (scan_fall && is_lsd) begin
            unblank_reg <= 1'b0; // see R11
            dp_pend_reg <= 1'b0;
        end else if (scan_fall && dp_pend_reg) begin
            unblank_reg <= 1'b1; // see R17
            dp_pend_reg <= 1'b0;
        end else if (scan_in && !zero_dig) begin
            unblank_reg <= 1'b1; // see R10
        end else if (dp_fall) begin
            if (dp_left) begin
                unblank_reg <= 1'b1; // see R10
            end else begin
                dp_pend_reg <= 1'b1; // see R17
            end
        end
    end
    // clr_n deliberately not used above: see R12

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    reg [6:0] seg_t; // true-polarity segments
    reg [3:0] bcd_t; // true-polarity bcd, complemented form

    always @* begin
        if (!scan_in) begin
            seg_t = 7'h7f; // see R04
            bcd_t = 4'hf;
        end else if (!blank_n) begin
            seg_t = 7'h7f; // see R15
            bcd_t = ~`FDC_DEC_ZERO;
        end else begin
            seg_t = blank_now ? 7'h7f : seg_dec(digit); // see R20 see R11
            bcd_t = ~digit;
        end
    end

    // registered data outputs with polarity select
    always @(posedge aclk) begin
        if (!aresetn) begin
            seg_out <= 7'h7f;
            bcd_out <= 4'hf;
            digit_sel <= 4'h0;
        end else begin
            seg_out <= true_pol ? seg_t : ~seg_t; // see R16
            bcd_out <= true_pol ? bcd_t : ~bcd_t; // see R16
            digit_sel <= scan_in ? sel_reg : 4'h0; // see R03 see R04
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    reg aw_hold_reg; // write address taken
    reg [3:0] aw_addr_reg;
    reg w_hold_reg; // write data taken
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // byte-lane merge
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (st[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // write path: address and data in either order, then response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FDC_RESP_OKAY;
            ctrl_reg <= `FDC_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_hold_reg && w_hold_reg) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg == `FDC_OFF_CTRL) begin
                    ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & `FDC_CTRL_RST;
                    s_axi_bresp <= `FDC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `FDC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read path: one cycle after address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FDC_RESP_OKAY;
            case (s_axi_araddr)
                `FDC_OFF_CTRL: s_axi_rdata <= ctrl_reg;
                `FDC_OFF_STAT: s_axi_rdata <= {22'h0, xfer_spaced, xfer_act_reg,
                    unblank_reg, carry_out, overflow_n, 1'b0, sel_reg};
                `FDC_OFF_LATCH: s_axi_rdata <= {16'h0, latch_q};
                `FDC_OFF_COUNT: s_axi_rdata <= {16'h0, cnt_reg};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `FDC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> sim/fdc_sva.sv
// concurrent checks on the counter pins
`timescale 1ns/1ps
module fdc_chk (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // device pins
    input logic count_in,
    input logic scan_in,
    input logic [6:0] seg_out,
    input logic [3:0] bcd_out,
    input logic [3:0] digit_sel,
    input logic overflow_n,
    input logic carry_out,
    // write answer
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready
);
    // true-mode codes for 0..9, {g..a}, 0 = lit
    localparam logic [6:0] seg_tab [0:9] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19,
        7'h12, 7'h02, 7'h78, 7'h00, 7'h10};
    logic [3:0] last_sel_reg; // last strobe seen
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // keep the last non-idle strobe
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_sel_reg <= 4'h0;
        end else if (digit_sel != 4'h0) begin
            last_sel_reg <= digit_sel;
        end
    end
    a_sel_onehot: assert property ($onehot0(digit_sel))
        else $error("digit select not one-hot");
    a_sel_step: assert property (
        digit_sel != 4'h0 && $past(digit_sel) == 4'h0 && last_sel_reg != 4'h0
        |-> digit_sel == {last_sel_reg[0], last_sel_reg[3:1]} || digit_sel == 4'h8)
        else $error("digit select skipped");
    a_scan_off: assert property (!scan_in [*4] |-> digit_sel == 4'h0)
        else $error("strobe on while scan low");
    a_idle_level: assert property (digit_sel == 4'h0 |->
        (seg_out == 7'h7f && bcd_out == 4'hf) || (seg_out == 7'h00 && bcd_out == 4'h0))
        else $error("outputs not off while idle");
    a_seg_decode: assert property (
        digit_sel != 4'h0 && seg_out != 7'h7f && seg_out != 7'h00
        |-> seg_out == seg_tab[~bcd_out] || seg_out == ~seg_tab[bcd_out])
        else $error("segments disagree with bcd");
    a_ovf_wrap: assert property ($fell(overflow_n) |-> $past(carry_out))
        else $error("overflow without wrap");
    a_carry_quiet: assert property (
        count_in [*3] |-> $stable(carry_out) && $stable(overflow_n))
        else $error("flags moved without count edge");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    c_carry: cover property (carry_out);
    c_ovf: cover property ($fell(overflow_n));
    c_lsd_zero: cover property (digit_sel == 4'h1 && seg_out == 7'h40);
endmodule

// >>> sim/fdc_disp_model.sv
// display side: point line made from the digit strobes
`timescale 1ns/1ps
module fdc_disp_model (
    // strobes from the counter
    input logic [3:0] digit_sel,
    // digit carrying the point, 0 for none
    input logic [3:0] dp_pos,
    // point line back to the counter
    output logic dp_n
);
    // pull the point line low while its digit is strobed
    assign dp_n = ~|(digit_sel & dp_pos);
endmodule

// >>> sim/fdc_top_tb.sv
// self-checking bench for the counter and display scanner
`timescale 1ns/1ps
module fdc_top_tb;
    // clock, reset and pins
    logic aclk = 1'b0, aresetn = 1'b0, count_in = 1'b1, scan_in = 1'b0, dp_n;
    logic [3:0] dp_pos = 4'h0, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, overflow_n, carry_out;
    logic [1:0] bresp, rresp;
    logic [6:0] seg_out;
    logic [3:0] bcd_out, digit_sel;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #20 aclk = ~aclk;
    fdc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .count_in(count_in), .scan_in(scan_in), .dp_n(dp_n),
        .seg_out(seg_out), .bcd_out(bcd_out), .digit_sel(digit_sel),
        .overflow_n(overflow_n), .carry_out(carry_out));
    fdc_disp_model disp_u (.digit_sel(digit_sel), .dp_pos(dp_pos), .dp_n(dp_n));
    // ----
    // helpers
    // ----
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard, run needs about 21000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            close_out;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // bus write, ready for the answer only after both items are taken
    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    // bus read, answer left waiting one cycle
    task rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        @(posedge aclk) rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk(rresp, 2'h0, "rresp");
        chk(rdata, exp, what);
    endtask
    task wr_ok(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk(r, 2'h0, "bresp");
    endtask
    // falling edges on the count line, then settle
    task count(input int n);
        repeat (n) begin
            @(posedge aclk) count_in <= 1'b0;
            @(posedge aclk) count_in <= 1'b1;
        end
        repeat (3) @(posedge aclk);
    endtask
    // low phase with outputs off, then a long high phase
    task scan_step(input logic [6:0] soff, input logic [3:0] boff);
        @(posedge aclk) scan_in <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(digit_sel, 4'h0, "sel off");
        chk(seg_out, soff, "seg off");
        chk(bcd_out, boff, "bcd off");
        scan_in <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
    // one scan from the most significant digit, ends back there
    task do_scan(input logic [27:0] segs, input logic [15:0] bcds, input logic [10:0] off);
        for (int i = 0; i < 4; i++) begin
            chk(digit_sel, 4'h8 >> i, "sel");
            chk(seg_out, segs[27-7*i -: 7], "seg");
            chk(bcd_out, bcds[15-4*i -: 4], "bcd");
            scan_step(off[10:4], off[3:0]);
        end
    endtask
    // ----
    // scenarios
    // ----
    task t_regs;
        logic [1:0] r;
        chk({digit_sel, seg_out, bcd_out}, 15'h07ff, "idle pins");
        chk({overflow_n, carry_out}, 2'h2, "flags");
        rd_chk(4'h0, 32'h1f, "ctrl reset");
        axi_wr(4'h4, 32'h0, r);
        chk(r, 2'h2, "read-only write");
        $display("test regs done");
    endtask
    task t_latch;
        wr_ok(4'h0, 32'h1d);
        count(3);
        rd_chk(4'h8, 32'h3, "latch live");
        wr_ok(4'h0, 32'h1f);
        repeat (25) @(posedge aclk);
        count(1);
        rd_chk(4'hc, 32'h4, "count");
        rd_chk(4'h8, 32'h3, "latch closed");
        count(2);
        rd_chk(4'h8, 32'h3, "latch held");
        $display("test latch done");
    endtask
    task t_display;
        scan_in <= 1'b1;
        repeat (8) @(posedge aclk);
        do_scan(28'hfffffb0, 16'hfffc, 11'h7ff);
        wr_ok(4'h0, 32'h17);
        repeat (4) @(posedge aclk);
        do_scan({21'h0, 7'h4f}, 16'h0003, 11'h000);
        wr_ok(4'h0, 32'h1b);
        repeat (4) @(posedge aclk);
        do_scan(28'hfffffff, 16'hffff, 11'h7ff);
        wr_ok(4'h0, 32'h1f);
        $display("test display done");
    endtask
    task t_point;
        dp_pos <= 4'h4;
        do_scan(28'hff02030, 16'hfffc, 11'h7ff);
        wr_ok(4'h0, 32'h0f);
        do_scan(28'hfffe030, 16'hfffc, 11'h7ff);
        wr_ok(4'h0, 32'h1f);
        dp_pos <= 4'h8;
        repeat (8) @(posedge aclk);
        chk(seg_out, 7'h40, "point digit");
        scan_step(7'h7f, 4'hf);
        scan_step(7'h7f, 4'hf);
        wr_ok(4'h0, 32'h1e);
        wr_ok(4'h0, 32'h1f);
        dp_pos <= 4'h0;
        repeat (8) @(posedge aclk);
        do_scan(28'h8102030, 16'hfffc, 11'h7ff);
        do_scan(28'hfffffb0, 16'hfffc, 11'h7ff);
        // reset while unblanked, blanking held low until the lsd has passed
        dp_pos <= 4'h8;
        repeat (4) @(posedge aclk);
        wr_ok(4'h0, 32'h1a);
        wr_ok(4'h0, 32'h1b);
        dp_pos <= 4'h0;
        do_scan(28'hfffffff, 16'hffff, 11'h7ff);
        wr_ok(4'h0, 32'h1f);
        repeat (4) @(posedge aclk);
        do_scan(28'hfffffb0, 16'hfffc, 11'h7ff);
        $display("test point done");
    endtask
    task t_wrap;
        count(9999);
        rd_chk(4'hc, 32'h9999, "count top");
        chk({overflow_n, carry_out}, 2'h3, "at top");
        count(1);
        chk({overflow_n, carry_out}, 2'h0, "wrapped");
        rd_chk(4'hc, 32'h0, "count wrap");
        count(1);
        rd_chk(4'hc, 32'h1, "count on");
        chk(overflow_n, 1'b0, "flag kept");
        $display("test wrap done");
    endtask
    task t_pin_reset;
        @(posedge aclk) aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        chk({overflow_n, digit_sel}, 5'h10, "in reset");
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(digit_sel, 4'h8, "msd after reset");
        rd_chk(4'hc, 32'h0, "count cleared");
        $display("test pin reset done");
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_latch;
        t_display;
        t_point;
        t_wrap;
        t_pin_reset;
        close_out;
    end
endmodule
bind fdc_top fdc_chk chk_u (.aclk(aclk), .aresetn(aresetn), .count_in(count_in),
    .scan_in(scan_in), .seg_out(seg_out), .bcd_out(bcd_out), .digit_sel(digit_sel),
    .overflow_n(overflow_n), .carry_out(carry_out), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
